// ===== design/irq_pkg.sv
// Purpose: constants for the interrupt capture and aggregation block
// Assumes: one bus clock, AXI4-Lite register access, 32-bit data
// Notes: byte offsets are word aligned; mode codes are 3 bits
//
// Operation
// - passthrough mode forwards source level unregistered to enable gating.
// - inverted passthrough forwards the inverted level unregistered.
// - level-held mode samples each edge and sets status on high.
// - a set status bit stays high until software clears it.
// - inverted level-held mode inverts input, otherwise like level-held.
// - rising mode sets status when sample high and delayed sample low.
// - falling mode sets status when sample low and delayed sample high.
// - device controller also combines the shell's service interrupts.
// - without device controller only user interrupts are recognised.
// - included transfer service forces the device controller in.
// - priority encoder is an optional build-time choice.
// - encoder reports 31 minus the highest pending bit position; bit 31 highest, bit 0 lowest.
package irq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_USER = 8;
    localparam int NUM_SVC = 4;
    localparam int MODE_W = 3;
    localparam int FIELD_W = 4;
    localparam int USER_BASE = 0;
    localparam int SVC_BASE = 8;
    localparam int ID_W = 8;
    localparam int TOP_BIT = 31;

    localparam logic [ADDR_W-1:0] OFF_USER_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_USER_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_USER_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DEV_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DEV_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DEV_PENDING = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_DEV_ID = 8'h18;

    localparam logic [NUM_USER-1:0] RST_USER_ENABLE = 8'h00;
    localparam logic [DATA_W-1:0] RST_USER_MODE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DEV_ENABLE = 32'h0000_0000;
    localparam logic [ID_W-1:0] ID_NONE = 8'hFF;

    localparam logic [MODE_W-1:0] MODE_PASS = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PASS_INV = 3'h1;
    localparam logic [MODE_W-1:0] MODE_HELD = 3'h2;
    localparam logic [MODE_W-1:0] MODE_HELD_INV = 3'h3;
    localparam logic [MODE_W-1:0] MODE_RISE = 3'h4;
    localparam logic [MODE_W-1:0] MODE_FALL = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_pkg

// ===== design/irq_capture_cell.sv
// Purpose: per-source capture stage with sticky status
// Assumes: source level synchronous to the bus clock
// Notes: set wins over a clear in the same cycle
`timescale 1ns/100ps
module irq_capture_cell
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic irqIn,
    input wire logic [irq_pkg::MODE_W-1:0] mode,
    input wire logic clearReq,
    output logic captured,
    output logic held
);
    import irq_pkg::*;

    logic sample;
    logic delayed;
    logic setEvent;

    // current and one-clock-delayed samples
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample <= 1'b0;
            delayed <= 1'b0;
        end
        else
        begin
            sample <= irqIn;
            delayed <= sample;
        end
    end

    always_comb
    begin
        unique case (mode)
            MODE_HELD: setEvent = irqIn;
            MODE_HELD_INV: setEvent = ~irqIn;
            MODE_RISE: setEvent = sample & ~delayed;
            MODE_FALL: setEvent = ~sample & delayed;
            default: setEvent = 1'b0;
        endcase
    end

    // sticky status, set wins over clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            held <= 1'b0;
        else if (setEvent)
            held <= 1'b1;
        else if (clearReq)
            held <= 1'b0;
    end

    always_comb
    begin
        unique case (mode)
            MODE_PASS: captured = irqIn;
            MODE_PASS_INV: captured = ~irqIn;
            MODE_HELD, MODE_HELD_INV, MODE_RISE, MODE_FALL: captured = held;
            default: captured = 1'b0;
        endcase
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_level_sets: assert property (
        mode == MODE_HELD && irqIn |=> held)
        else $error("level-held source high but status not set");
    a_held_sticky: assert property (held && !clearReq |=> held)
        else $error("status dropped without a clear");
    a_inv_sets: assert property (
        mode == MODE_HELD_INV && !irqIn |=> held)
        else $error("inverted level-held low input did not set status");
    a_rise_sets: assert property (
        mode == MODE_RISE && !irqIn ##1 mode == MODE_RISE && irqIn
        ##1 mode == MODE_RISE |=> held)
        else $error("rising edge not latched");
    a_fall_sets: assert property (
        mode == MODE_FALL && irqIn ##1 mode == MODE_FALL && !irqIn
        ##1 mode == MODE_FALL |=> held)
        else $error("falling edge not latched");
    a_pass_level: assert property (
        mode == MODE_PASS |-> captured == irqIn)
        else $error("passthrough level altered");
    a_pass_inv: assert property (
        mode == MODE_PASS_INV |-> captured != irqIn)
        else $error("inverted passthrough not inverted");
endmodule : irq_capture_cell

// ===== design/ip_interrupt_capture_ctrl.sv
// Purpose: interrupt capture, gating, aggregation and priority encoding
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: status registers clear on read; irq is a registered level
`timescale 1ns/100ps
module ip_interrupt_capture_ctrl
#(
    parameter bit USE_DEVICE_ISC = 1'b1,
    parameter bit USE_PRIO_ENC = 1'b1,
    parameter bit HAS_DMA = 1'b0
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [irq_pkg::NUM_USER-1:0] userIrq,
    input wire logic [irq_pkg::NUM_SVC-1:0] svcIrq,
    input wire logic [irq_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [irq_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [irq_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [irq_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    output logic [irq_pkg::ID_W-1:0] irqId
);
    import irq_pkg::*;

    // transfer service forces the device controller in
    localparam bit DEVICE_ISC_ON = USE_DEVICE_ISC | HAS_DMA;

    logic [NUM_USER-1:0] userEnable;
    logic [DATA_W-1:0] userMode;
    logic [DATA_W-1:0] devEnable;
    logic [NUM_SVC-1:0] svcStatus;
    logic [NUM_USER-1:0] captured;
    logic [NUM_USER-1:0] held;
    logic [NUM_USER-1:0] userPending;
    logic [DATA_W-1:0] devVector;
    logic [DATA_W-1:0] devPending;
    logic [ID_W-1:0] next_irqId;
    logic next_irq;

    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddrHeld;
    logic [DATA_W-1:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic awFire;
    logic wFire;
    logic bFire;
    logic arFire;
    logic rFire;
    logic doWrite;
    logic next_awHeld;
    logic next_wHeld;
    logic rBusy;
    logic [ADDR_W-1:0] wrWord;
    logic [ADDR_W-1:0] rdWord;
    logic wrOk;
    logic rdOk;
    logic [DATA_W-1:0] readValue;
    logic clearUser;
    logic clearDev;
    logic [DATA_W-1:0] enableMerged;

    assign awFire = awvalid & awready;
    assign wFire = wvalid & wready;
    assign bFire = bvalid & bready;
    assign arFire = arvalid & arready;
    assign rFire = rvalid & rready;
    assign doWrite = awHeld & wHeld & ~bvalid;
    assign wrWord = {awAddrHeld[ADDR_W-1:2], 2'h0};
    assign rdWord = {araddr[ADDR_W-1:2], 2'h0};
    assign next_awHeld = (awHeld | awFire) & ~bFire;
    assign next_wHeld = (wHeld | wFire) & ~bFire;
    assign rBusy = (rvalid | arFire) & ~rFire;
    assign clearUser = arFire && rdWord == OFF_USER_STATUS;
    assign clearDev = arFire && rdWord == OFF_DEV_STATUS;

    function automatic logic [DATA_W-1:0] mergeBytes(
        input logic [DATA_W-1:0] oldValue,
        input logic [DATA_W-1:0] newValue,
        input logic [3:0] strobe
    );
        logic [DATA_W-1:0] result;
        result = oldValue;
        for (int b = 0; b < 4; b++)
        begin
            if (strobe[b])
                result[b*8 +: 8] = newValue[b*8 +: 8];
        end
        return result;
    endfunction : mergeBytes

    assign enableMerged = mergeBytes(DATA_W'(userEnable), wDataHeld,
        wStrbHeld);

    // per-source capture stages
    generate
        for (genvar i = 0; i < NUM_USER; i++)
        begin : g_cell
            irq_capture_cell u_cell
            (
                .clock(clock),
                .rst_n(rst_n),
                .irqIn(userIrq[i]),
                .mode(userMode[i*FIELD_W +: MODE_W]),
                .clearReq(clearUser),
                .captured(captured[i]),
                .held(held[i])
            );
        end
    endgenerate

    // source enable gating
    assign userPending = captured & userEnable;

    // service interrupts, sticky, set wins over read clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            svcStatus <= '0;
        else if (DEVICE_ISC_ON)
            svcStatus <= (svcStatus & ~{NUM_SVC{clearDev}}) | svcIrq;
        else
            svcStatus <= '0;
    end

    // device-level vector: user sources plus shell services
    always_comb
    begin
        devVector = '0;
        if (DEVICE_ISC_ON)
        begin
            devVector[USER_BASE +: NUM_USER] = userPending;
            devVector[SVC_BASE +: NUM_SVC] = svcStatus;
        end
    end

    assign devPending = devVector & devEnable;

    // priority scan, later hits are higher priority
    always_comb
    begin
        next_irqId = ID_NONE;
        if (USE_PRIO_ENC)
        begin
            for (int i = 0; i < DATA_W; i++)
            begin
                if (devPending[i])
                    next_irqId = ID_W'(TOP_BIT - i);
            end
        end
    end

    always_comb
    begin
        if (DEVICE_ISC_ON)
            next_irq = |devPending;
        else
            next_irq = |userPending;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
            irqId <= ID_NONE;
        end
        else
        begin
            irq <= next_irq;
            irqId <= next_irqId;
        end
    end

    // write address and data channels
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            awAddrHeld <= '0;
            wDataHeld <= '0;
            wStrbHeld <= '0;
        end
        else
        begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awready <= ~next_awHeld;
            wready <= ~next_wHeld;
            if (awFire)
                awAddrHeld <= awaddr;
            if (wFire)
            begin
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
        end
    end

    always_comb
    begin
        unique case (wrWord)
            OFF_USER_ENABLE, OFF_USER_MODE: wrOk = 1'b1;
            OFF_DEV_ENABLE: wrOk = DEVICE_ISC_ON;
            default: wrOk = 1'b0;
        endcase
    end

    // register writes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            userEnable <= RST_USER_ENABLE;
            userMode <= RST_USER_MODE;
            devEnable <= RST_DEV_ENABLE;
        end
        else if (doWrite)
        begin
            if (wrWord == OFF_USER_ENABLE)
                userEnable <= enableMerged[NUM_USER-1:0];
            if (wrWord == OFF_USER_MODE)
                userMode <= mergeBytes(userMode, wDataHeld, wStrbHeld);
            if (wrWord == OFF_DEV_ENABLE && DEVICE_ISC_ON)
                devEnable <= mergeBytes(devEnable, wDataHeld, wStrbHeld);
        end
    end

    // write response
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid <= 1'b1;
            bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bFire)
            bvalid <= 1'b0;
    end

    // read decode
    always_comb
    begin
        readValue = '0;
        rdOk = 1'b1;
        unique case (rdWord)
            OFF_USER_STATUS: readValue[NUM_USER-1:0] = captured;
            OFF_USER_ENABLE: readValue[NUM_USER-1:0] = userEnable;
            OFF_USER_MODE: readValue = userMode;
            OFF_DEV_STATUS: readValue = devVector;
            OFF_DEV_ENABLE: readValue = devEnable;
            OFF_DEV_PENDING: readValue = devPending;
            OFF_DEV_ID: readValue[ID_W-1:0] = irqId;
            default: rdOk = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else
        begin
            arready <= ~rBusy;
            if (arFire)
            begin
                rvalid <= 1'b1;
                rdata <= readValue;
                rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rFire)
                rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_gate_blocks: assert property (
        (captured & userEnable) == '0 && (!DEVICE_ISC_ON || svcStatus == '0)
        |=> !irq)
        else $error("disabled sources raised irq");
    a_gate_passes: assert property (
        (captured & userEnable
            & (DEVICE_ISC_ON ? devEnable[NUM_USER-1:0] : '1)) != '0
        |=> irq)
        else $error("enabled source did not raise irq");
    a_svc_combined: assert property (
        DEVICE_ISC_ON && devEnable[SVC_BASE] && svcIrq[0] [*2] |=> irq)
        else $error("service interrupt not combined");
    a_user_only: assert property (!DEVICE_ISC_ON |-> devPending == '0)
        else $error("device vector active without device controller");
    a_dma_forces: assert property (HAS_DMA |-> DEVICE_ISC_ON)
        else $error("transfer service without device controller");
    a_prio_absent: assert property (
        !USE_PRIO_ENC |=> irqId == ID_NONE)
        else $error("identifier driven without encoder");
    a_prio_top: assert property (
        USE_PRIO_ENC && devPending[SVC_BASE+NUM_SVC-1] |=> irqId == 8'h14)
        else $error("highest source bit did not win");
    a_prio_count: assert property (
        USE_PRIO_ENC && devPending[DATA_W-1:7] == 25'h1 |=> irqId == 8'h18)
        else $error("identifier not 31 minus position");
    a_irq_level: assert property (next_irq |=> irq ##0 $past(next_irq))
        else $error("irq does not follow pending");
    a_write_resp: assert property (doWrite |=> bvalid)
        else $error("write not answered");
    a_read_resp: assert property (arFire |=> rvalid)
        else $error("read not answered");
    a_svc_sticky: assert property (
        svcStatus[0] && !clearDev |=> svcStatus[0])
        else $error("service status dropped without a read");

    c_user_held: cover property (held[0] && userEnable[0] ##1 irq);
    c_svc_irq: cover property (svcStatus != '0 ##[1:3] irq);
    c_write_done: cover property (bFire && bresp == RESP_OKAY);
    c_status_read: cover property (clearUser ##1 rFire);
endmodule : ip_interrupt_capture_ctrl

// ===== dv/irq_source_model.sv
// Purpose: user-logic and service interrupt sources beside the block
// Assumes: levels change just after a rising bus clock edge
// Notes: registered copy of what the bench asks for; zero in reset
`timescale 1ns/100ps
module irq_source_model
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [irq_pkg::NUM_USER-1:0] wantUser,
    input wire logic [irq_pkg::NUM_SVC-1:0] wantSvc,
    output logic [irq_pkg::NUM_USER-1:0] userIrq,
    output logic [irq_pkg::NUM_SVC-1:0] svcIrq
);
    import irq_pkg::*;

    // levels held from one edge to the next
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            userIrq <= '0;
            svcIrq <= '0;
        end
        else
        begin
            userIrq <= wantUser;
            svcIrq <= wantSvc;
        end
    end
endmodule : irq_source_model

// ===== dv/tb.sv
// Purpose: self-checking bench for the interrupt capture block
// Assumes: default build, device controller and encoder present
// Notes: xorshift stimulus from a fixed seed plus corner patterns
`timescale 1ns/100ps
module tb;
    import irq_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] wantUser = 8'h00;
    logic [3:0] wantSvc = 4'h0;
    logic [NUM_USER-1:0] userIrq;
    logic [NUM_SVC-1:0] svcIrq;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic irq;
    logic [7:0] irqId;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_14C9;
    logic [31:0] d, modeWord, p, rnd;
    logic [1:0] r;
    logic [7:0] en, v0, v1, v2, e;

    always #50 clock = ~clock;

    irq_source_model src_u (.clock(clock), .rst_n(rst_n),
        .wantUser(wantUser), .wantSvc(wantSvc),
        .userIrq(userIrq), .svcIrq(svcIrq));

    ip_interrupt_capture_ctrl dut_u (.clock(clock), .rst_n(rst_n),
        .userIrq(userIrq), .svcIrq(svcIrq), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq), .irqId(irqId));

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    // status since the clearing read: a held through v0, then b, then c
    function automatic logic exp_bit(logic [2:0] m, logic a, logic b,
                                     logic c);
        case (m)
            MODE_PASS: return c;
            MODE_PASS_INV: return !c;
            MODE_HELD: return a | b | c;
            MODE_HELD_INV: return !(a & b & c);
            MODE_RISE: return (!a & b) | (!b & c);
            MODE_FALL: return (a & !b) | (b & !c);
            default: return 1'b0;
        endcase
    endfunction : exp_bit

    function automatic logic [7:0] exp_id(logic [31:0] pend);
        for (int i = 31; i >= 0; i--)
        begin
            if (pend[i])
                return 8'(31 - i);
        end
        return ID_NONE;
    endfunction : exp_id

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic axi_write(input logic [7:0] a, input logic [31:0] dv,
                             output logic [1:0] rs);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone))
        begin
            @(posedge clock);
            if (!awDone && awready)
            begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready)
            begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] dv,
                            output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask : axi_read

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        axi_read(OFF_USER_ENABLE, d, r);
        check("userEnable", 32'(RST_USER_ENABLE), d);
        axi_read(OFF_USER_MODE, d, r);
        check("userMode", RST_USER_MODE, d);
        axi_read(OFF_DEV_ENABLE, d, r);
        check("devEnable", RST_DEV_ENABLE, d);
        axi_read(OFF_DEV_ID, d, r);
        check("devId idle", 32'(ID_NONE), d);
        axi_read(8'h1C, d, r);
        check("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
        check("unmapped rdata", 32'h0000_0000, d);
        axi_write(OFF_DEV_ID, 32'h0000_0001, r);
        check("read-only bresp", 32'(RESP_SLVERR), 32'(r));
        axi_write(8'h1C, 32'h0000_0001, r);
        check("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
        axi_write(OFF_DEV_ENABLE, 32'hFFFF_FFFF, r);
        check("devEnable bresp", 32'(RESP_OKAY), 32'(r));
        for (int k = 0; k < 8; k++)
        begin
            modeWord = (32'h7654_3210 << (4 * k)) |
                       (32'h7654_3210 >> (32 - 4 * k));
            rnd = next_rand();
            en = (k == 0) ? 8'hFF : rnd[7:0];
            v0 = rnd[15:8];
            v1 = rnd[23:16];
            v2 = rnd[31:24];
            if (k == 1)
            begin
                v0 = 8'h00;
                v1 = 8'hFF;
                v2 = 8'h00;
            end
            if (k == 2)
            begin
                v0 = 8'hFF;
                v1 = 8'h00;
                v2 = 8'hFF;
            end
            axi_write(OFF_USER_MODE, modeWord, r);
            axi_write(OFF_USER_ENABLE, {24'h0, en}, r);
            check("userEnable bresp", 32'(RESP_OKAY), 32'(r));
            wantUser <= v0;
            repeat (8) @(posedge clock);
            axi_read(OFF_USER_STATUS, d, r);
            wantUser <= v1;
            repeat (8) @(posedge clock);
            wantUser <= v2;
            repeat (8) @(posedge clock);
            for (int i = 0; i < 8; i++)
                e[i] = exp_bit(modeWord[4*i +: 3], v0[i], v1[i], v2[i]);
            p = {24'h0, e & en};
            check("irq", {31'h0, |p}, {31'h0, irq});
            check("irqId", 32'(exp_id(p)), 32'(irqId));
            axi_read(OFF_DEV_PENDING, d, r);
            check("devPending", p, d);
            axi_read(OFF_USER_STATUS, d, r);
            check("status lo", 32'(e[3:0]), d & 32'hF);
            check("status hi", 32'(e[7:4]), d >> 4);
        end
        axi_write(OFF_USER_ENABLE, 32'h0000_0000, r);
        wantSvc <= 4'hD;
        repeat (2) @(posedge clock);
        wantSvc <= 4'h0;
        repeat (6) @(posedge clock);
        check("svc irq", 32'h0000_0001, {31'h0, irq});
        check("svc irqId", 32'(exp_id(32'h0000_0D00)), 32'(irqId));
        axi_write(OFF_DEV_ENABLE, 32'h0000_0000, r);
        repeat (2) @(posedge clock);
        check("masked irq", 32'h0000_0000, {31'h0, irq});
        check("masked irqId", 32'(ID_NONE), 32'(irqId));
        axi_read(OFF_DEV_STATUS, d, r);
        check("devStatus", 32'h0000_0D00, d);
        axi_read(OFF_DEV_STATUS, d, r);
        check("devStatus cleared", 32'h0000_0000, d);
        wrap_up();
    end
endmodule : tb
